// ### hw/clk_ctrl.sv
// Oscillator, PLL and master clock control with an APB register file.
// Assumes slow_clk and main_osc_clk are asynchronous and the PLL ticks synchronous, all
// far slower than clock; generated clocks leave as one-cycle enables.
//
// Behaviour
// - After reset the oscillator is off and the slow clock is selected.
// - Clearing the oscillator enable clears the stable flag at once.
// - Enable write clears stable, counts down once per eight slow cycles.
// - The startup count field is eight bits, about 62 ms at most.
// - Counter at zero sets stable; masked interrupt may follow.
// - Frequency counting starts at the slow rise after stable.
// - Sixteenth slow fall stops counting and sets the ready flag.
// - Each PLL input divider takes values 1 to 255.
// - Divide value zero holds divider and PLL low; resets to zero.
// - PLL output equals source times gain plus one over divide.
// - Gain zero turns the PLL off; nonzero turns it on if divide is nonzero.
// - Re-enable or parameter change clears lock and reloads counter.
// - Lock counter counts slow cycles; zero sets lock, may interrupt.
// - Master clock source is selectable, prescaled by 1 to 64.
// - Master clock is divided down from the processor clock.
// - Master clock register write clears ready until clock settles.
// - Processor clock on after reset, disable register stops it.
// - Enabled fast or normal interrupt restarts the processor clock.
// - Clock stops only after the current instruction completes.
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps
module clk_ctrl
    import clk_ctrl_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [clk_ctrl_pkg::ADDR_W-1:0] paddr,
    input wire logic [clk_ctrl_pkg::DATA_W-1:0] pwdata,
    output logic [clk_ctrl_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic slow_clk,
    input wire logic main_osc_clk,
    input wire logic pll_a_clk,
    input wire logic pll_b_clk,
    input wire logic fiq_req,
    input wire logic irq_req,
    input wire logic instr_done,
    output logic osc_enable_bit,
    output logic osc_bypass_bit,
    output logic [clk_ctrl_pkg::DIV_W-1:0] pll_a_div,
    output logic [clk_ctrl_pkg::GAIN_W-1:0] pll_a_gain,
    output logic pll_a_run,
    output logic [clk_ctrl_pkg::DIV_W-1:0] pll_b_div,
    output logic [clk_ctrl_pkg::GAIN_W-1:0] pll_b_gain,
    output logic pll_b_run,
    output logic master_clk_en,
    output logic cpu_clk_en,
    output logic pmc_irq
);
    import clk_ctrl_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers and edge detection.
    logic slow_s1_ff, slow_s2_ff, slow_s3_ff;
    logic main_s1_ff, main_s2_ff, main_s3_ff;
    logic slow_rise, slow_fall, main_rise;

    always_ff @(posedge clock) begin
        if (srst) begin
            slow_s1_ff <= 1'b0;
            slow_s2_ff <= 1'b0;
            slow_s3_ff <= 1'b0;
            main_s1_ff <= 1'b0;
            main_s2_ff <= 1'b0;
            main_s3_ff <= 1'b0;
        end else begin
            slow_s1_ff <= slow_clk;
            slow_s2_ff <= slow_s1_ff;
            slow_s3_ff <= slow_s2_ff;
            main_s1_ff <= main_osc_clk;
            main_s2_ff <= main_s1_ff;
            main_s3_ff <= main_s2_ff;
        end
    end

    assign slow_rise = slow_s2_ff & ~slow_s3_ff;
    assign slow_fall = ~slow_s2_ff & slow_s3_ff;
    assign main_rise = main_s2_ff & ~main_s3_ff;

    ////////////////////////////////////////////////////////////////////////
    // APB decode.
    logic wr_en, setup;
    logic sel_scer, sel_scdr, sel_scsr, sel_mor, sel_mcfr;
    logic sel_plla, sel_pllb, sel_mckr, sel_ier, sel_idr, sel_sr, sel_imr;
    logic addr_hit;
    logic [DATA_W-1:0] rd_word;
    logic [DATA_W-1:0] prdata_ff;

    assign sel_scer = (paddr == OFS_SCER);
    assign sel_scdr = (paddr == OFS_SCDR);
    assign sel_scsr = (paddr == OFS_SCSR);
    assign sel_mor = (paddr == OFS_MOR);
    assign sel_mcfr = (paddr == OFS_MCFR);
    assign sel_plla = (paddr == OFS_PLLA);
    assign sel_pllb = (paddr == OFS_PLLB);
    assign sel_mckr = (paddr == OFS_MCKR);
    assign sel_ier = (paddr == OFS_IER);
    assign sel_idr = (paddr == OFS_IDR);
    assign sel_sr = (paddr == OFS_SR);
    assign sel_imr = (paddr == OFS_IMR);
    assign addr_hit = sel_scer | sel_scdr | sel_scsr | sel_mor | sel_mcfr
        | sel_plla | sel_pllb | sel_mckr | sel_ier | sel_idr | sel_sr
        | sel_imr;
    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pwrite & addr_hit;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_hit;
    assign prdata = prdata_ff;

    ////////////////////////////////////////////////////////////////////////
    // Main oscillator control.
    logic osc_en_ff, osc_byp_ff;
    logic [OSC_CNT_W-1:0] osc_cnt_ff;
    logic osc_write, osc_start, osc_tick, osc_stable;

    assign osc_write = wr_en & sel_mor;
    assign osc_start = osc_write & pwdata[MOR_EN_BIT];
    assign osc_enable_bit = osc_en_ff;
    assign osc_bypass_bit = osc_byp_ff;

    always_ff @(posedge clock) begin
        if (srst) begin
            osc_en_ff <= 1'b0;
            osc_byp_ff <= 1'b0;
            osc_cnt_ff <= '0;
        end else if (osc_write) begin
            osc_en_ff <= pwdata[MOR_EN_BIT];
            osc_byp_ff <= pwdata[MOR_BYP_BIT];
            osc_cnt_ff <= pwdata[MOR_CNT_LSB +: OSC_CNT_W];
        end
    end

    pow2_divider #(.CNT_W(3)) u_osc_div (
        .clock(clock),
        .srst(srst),
        .tick(slow_rise),
        .log2_ratio(OSC_TICK_LOG2),
        .tick_out(osc_tick)
    );

    wait_counter #(.CNT_W(OSC_CNT_W)) u_osc_wait (
        .clock(clock),
        .srst(srst),
        .run(osc_en_ff | osc_start),
        .load(osc_start),
        .load_value(pwdata[MOR_CNT_LSB +: OSC_CNT_W]),
        .tick(osc_tick),
        .done(osc_stable)
    );

    ////////////////////////////////////////////////////////////////////////
    // Main clock frequency measurement.
    meas_state_type meas_ff, nxt_meas;
    logic [MCFR_CNT_W-1:0] meas_cnt_ff;
    logic [4:0] fall_cnt_ff;

    always_comb begin
        nxt_meas = meas_ff;
        unique case (meas_ff)
            MEAS_IDLE: if (osc_stable) nxt_meas = MEAS_WAIT;
            MEAS_WAIT: if (slow_rise) nxt_meas = MEAS_RUN;
            MEAS_RUN: if (slow_fall && fall_cnt_ff == MEAS_PERIODS - 1'b1)
                nxt_meas = MEAS_DONE;
            MEAS_DONE: nxt_meas = MEAS_DONE;
        endcase
        if (!osc_stable) begin
            nxt_meas = MEAS_IDLE;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            meas_ff <= MEAS_IDLE;
            meas_cnt_ff <= '0;
            fall_cnt_ff <= '0;
        end else begin
            meas_ff <= nxt_meas;
            if (meas_ff == MEAS_IDLE) begin
                meas_cnt_ff <= '0;
                fall_cnt_ff <= '0;
            end else if (meas_ff == MEAS_RUN) begin
                if (main_rise) begin
                    meas_cnt_ff <= meas_cnt_ff + 1'b1;
                end
                if (slow_fall) begin
                    fall_cnt_ff <= fall_cnt_ff + 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Input dividers and PLLs, one slice per PLL.
    logic [DIV_W-1:0] div_ff [2];
    logic [GAIN_W-1:0] gain_ff [2];
    logic [LOCK_CNT_W-1:0] lock_cnt_ff [2];
    logic [1:0] pll_run, pll_locked, pll_tick;
    logic [DATA_W-1:0] pll_word [2];

    assign pll_tick = {pll_b_clk, pll_a_clk};

    for (genvar i = 0; i < 2; i++) begin : g_pll
        logic pll_write, pll_change;
        logic [DIV_W-1:0] wr_div;
        logic [GAIN_W-1:0] wr_gain;

        assign pll_write = wr_en & ((i == 0) ? sel_plla : sel_pllb);
        assign wr_div = pwdata[PLL_DIV_LSB +: DIV_W];
        assign wr_gain = pwdata[PLL_GAIN_LSB +: GAIN_W];
        assign pll_change = pll_write
            & ((wr_div != div_ff[i]) | (wr_gain != gain_ff[i])
               | (pwdata[PLL_CNT_LSB +: LOCK_CNT_W] != lock_cnt_ff[i]));
        assign pll_run[i] = (div_ff[i] != '0) & (gain_ff[i] != '0);
        assign pll_word[i] = {{(DATA_W - PLL_GAIN_LSB - GAIN_W){1'b0}},
            gain_ff[i], {(PLL_GAIN_LSB - PLL_CNT_LSB - LOCK_CNT_W){1'b0}},
            lock_cnt_ff[i], div_ff[i]};

        always_ff @(posedge clock) begin
            if (srst) begin
                div_ff[i] <= DIV_RST;
                gain_ff[i] <= GAIN_RST;
                lock_cnt_ff[i] <= '0;
            end else if (pll_write) begin
                div_ff[i] <= wr_div;
                gain_ff[i] <= wr_gain;
                lock_cnt_ff[i] <= pwdata[PLL_CNT_LSB +: LOCK_CNT_W];
            end
        end

        wait_counter #(.CNT_W(LOCK_CNT_W)) u_lock (
            .clock(clock),
            .srst(srst),
            .run(pll_run[i] | pll_change),
            .load(pll_change),
            .load_value(pwdata[PLL_CNT_LSB +: LOCK_CNT_W]),
            .tick(slow_rise),
            .done(pll_locked[i])
        );
    end

    assign pll_a_div = div_ff[0];
    assign pll_a_gain = gain_ff[0];
    assign pll_a_run = pll_run[0];
    assign pll_b_div = div_ff[1];
    assign pll_b_gain = gain_ff[1];
    assign pll_b_run = pll_run[1];

    ////////////////////////////////////////////////////////////////////////
    // Master clock selection, prescaler and divider.
    logic [1:0] src_sel_ff;
    logic [2:0] scale_ff;
    logic [1:0] ratio_ff;
    logic mst_wait_ff;
    logic mckr_write, src_tick, cpu_tick, mst_tick;
    logic [2:0] ratio_log2;

    assign mckr_write = wr_en & sel_mckr;

    assign src_tick = (src_sel_ff == SRC_SLOW) ? slow_rise
        : (src_sel_ff == SRC_MAIN) ? (main_rise & osc_stable)
        : (src_sel_ff == SRC_PLLA) ? (pll_tick[0] & pll_locked[0])
        : (pll_tick[1] & pll_locked[1]);
    // Ratio code 3 is treated as 4 so that no code leaves the clock stuck.
    assign ratio_log2 = (ratio_ff == 2'h0) ? 3'h0
        : (ratio_ff == 2'h1) ? 3'h1 : 3'h2;

    always_ff @(posedge clock) begin
        if (srst) begin
            src_sel_ff <= SRC_RST;
            scale_ff <= SCALE_RST;
            ratio_ff <= RATIO_RST;
        end else if (mckr_write) begin
            src_sel_ff <= pwdata[MCKR_SRC_LSB +: 2];
            scale_ff <= pwdata[MCKR_SCALE_LSB +: 3];
            ratio_ff <= pwdata[MCKR_RATIO_LSB +: 2];
        end
    end

    pow2_divider #(.CNT_W(6)) u_scale (
        .clock(clock),
        .srst(srst),
        .tick(src_tick),
        .log2_ratio(scale_ff),
        .tick_out(cpu_tick)
    );

    pow2_divider #(.CNT_W(2)) u_ratio (
        .clock(clock),
        .srst(srst),
        .tick(cpu_tick),
        .log2_ratio(ratio_log2),
        .tick_out(mst_tick)
    );

    always_ff @(posedge clock) begin
        if (srst) begin
            mst_wait_ff <= 1'b0;
        end else if (mckr_write) begin
            mst_wait_ff <= 1'b1;
        end else if (mst_tick) begin
            mst_wait_ff <= 1'b0;
        end
    end

    assign master_clk_en = mst_tick;

    ////////////////////////////////////////////////////////////////////////
    // Processor clock gating for idle mode.
    logic cpu_on_ff, stop_pend_ff, wake;

    assign wake = fiq_req | irq_req;

    always_ff @(posedge clock) begin
        if (srst) begin
            cpu_on_ff <= 1'b1;
            stop_pend_ff <= 1'b0;
        end else if (wake || (wr_en && sel_scer && pwdata[SCSR_CPU_BIT])) begin
            cpu_on_ff <= 1'b1;
            stop_pend_ff <= 1'b0;
        end else if (wr_en && sel_scdr && pwdata[SCSR_CPU_BIT]) begin
            stop_pend_ff <= 1'b1;
        end else if (stop_pend_ff && instr_done) begin
            cpu_on_ff <= 1'b0;
            stop_pend_ff <= 1'b0;
        end
    end

    assign cpu_clk_en = cpu_tick & cpu_on_ff;

    ////////////////////////////////////////////////////////////////////////
    // Status, mask and read data.
    logic [SR_W-1:0] status, imr_ff;

    assign status = {~mst_wait_ff, pll_locked[1], pll_locked[0],
        osc_stable};

    always_ff @(posedge clock) begin
        if (srst) begin
            imr_ff <= IMR_RST;
        end else if (wr_en && sel_ier) begin
            imr_ff <= imr_ff | pwdata[SR_W-1:0];
        end else if (wr_en && sel_idr) begin
            imr_ff <= imr_ff & ~pwdata[SR_W-1:0];
        end
    end

    assign pmc_irq = |(status & imr_ff);

    assign rd_word = sel_scsr ? {{(DATA_W - 1){1'b0}}, cpu_on_ff}
        : sel_mor ? {{(DATA_W - MOR_CNT_LSB - OSC_CNT_W){1'b0}}, osc_cnt_ff,
            6'h00, osc_byp_ff, osc_en_ff}
        : sel_mcfr ? {{(DATA_W - MCFR_RDY_BIT - 1){1'b0}},
            meas_ff == MEAS_DONE, meas_cnt_ff}
        : sel_plla ? pll_word[0]
        : sel_pllb ? pll_word[1]
        : sel_mckr ? {{(DATA_W - 10){1'b0}}, ratio_ff, 3'h0, scale_ff,
            src_sel_ff}
        : sel_sr ? {{(DATA_W - SR_W){1'b0}}, status}
        : sel_imr ? {{(DATA_W - SR_W){1'b0}}, imr_ff}
        : '0;

    // Read data is caught in the setup cycle so it comes from a flop.
    always_ff @(posedge clock) begin
        if (srst) begin
            prdata_ff <= '0;
        end else if (setup && !pwrite) begin
            prdata_ff <= rd_word;
        end
    end
endmodule // clk_ctrl

// ### hw/clk_ctrl_pkg.sv
// Constants, register map and state codes for the clock controller.
// Assumes a 32-bit APB master and a 200 MHz system clock.
package clk_ctrl_pkg;

    ////////////////////////////////////////////////////////////////////////
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] OFS_SCER = 8'h00;
    localparam logic [7:0] OFS_SCDR = 8'h04;
    localparam logic [7:0] OFS_SCSR = 8'h08;
    localparam logic [7:0] OFS_MOR = 8'h20;
    localparam logic [7:0] OFS_MCFR = 8'h24;
    localparam logic [7:0] OFS_PLLA = 8'h28;
    localparam logic [7:0] OFS_PLLB = 8'h2c;
    localparam logic [7:0] OFS_MCKR = 8'h30;
    localparam logic [7:0] OFS_IER = 8'h60;
    localparam logic [7:0] OFS_IDR = 8'h64;
    localparam logic [7:0] OFS_SR = 8'h68;
    localparam logic [7:0] OFS_IMR = 8'h6c;

    ////////////////////////////////////////////////////////////////////////
    localparam int MOR_EN_BIT = 0;
    localparam int MOR_BYP_BIT = 1;
    localparam int MOR_CNT_LSB = 8;
    localparam int OSC_CNT_W = 8;
    localparam int PLL_DIV_LSB = 0;
    localparam int DIV_W = 8;
    localparam int PLL_CNT_LSB = 8;
    localparam int LOCK_CNT_W = 6;
    localparam int PLL_GAIN_LSB = 16;
    localparam int GAIN_W = 11;
    localparam int MCKR_SRC_LSB = 0;
    localparam int MCKR_SCALE_LSB = 2;
    localparam int MCKR_RATIO_LSB = 8;
    localparam int MCFR_CNT_W = 16;
    localparam int MCFR_RDY_BIT = 16;
    localparam int SR_STABLE = 0;
    localparam int SR_LOCK_A = 1;
    localparam int SR_LOCK_B = 2;
    localparam int SR_MASTER_RDY = 3;
    localparam int SR_W = 4;
    localparam int SCSR_CPU_BIT = 0;

    ////////////////////////////////////////////////////////////////////////
    localparam logic [1:0] SRC_SLOW = 2'h0;
    localparam logic [1:0] SRC_MAIN = 2'h1;
    localparam logic [1:0] SRC_PLLA = 2'h2;
    localparam logic [1:0] SRC_PLLB = 2'h3;
    localparam logic [1:0] SRC_RST = SRC_SLOW;
    localparam logic [2:0] SCALE_RST = 3'h0;
    localparam logic [1:0] RATIO_RST = 2'h0;
    localparam logic [DIV_W-1:0] DIV_RST = 8'h00;
    localparam logic [GAIN_W-1:0] GAIN_RST = 11'h000;
    localparam logic [SR_W-1:0] IMR_RST = 4'h0;

    ////////////////////////////////////////////////////////////////////////
    localparam logic [2:0] OSC_TICK_LOG2 = 3'h3;
    localparam logic [4:0] MEAS_PERIODS = 5'h10;
    localparam int OSC_MAX_STARTUP_MS = 62;

    typedef enum logic [3:0] {
        MEAS_IDLE = 4'b0001,
        MEAS_WAIT = 4'b0010,
        MEAS_RUN = 4'b0100,
        MEAS_DONE = 4'b1000
    } meas_state_type;

endpackage

// ### hw/pow2_divider.sv
// Divides a stream of one-cycle ticks by a power of two.
// Assumes tick is a one-cycle pulse in the system clock domain.
`timescale 1ns/1ps
module pow2_divider #(
    parameter int CNT_W = 6
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic tick,
    input wire logic [2:0] log2_ratio,
    output logic tick_out
);
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] mask;

    // Ratio 1 lets every tick through; the count only matters above it.
    assign mask = CNT_W'((1 << log2_ratio) - 1);
    assign tick_out = tick & ((cnt_ff & mask) == mask);

    always_ff @(posedge clock) begin
        if (srst) begin
            cnt_ff <= '0;
        end else if (tick) begin
            cnt_ff <= cnt_ff + 1'b1;
        end
    end
endmodule // pow2_divider

// ### hw/wait_counter.sv
// Loadable down counter that raises a done flag after a tick count.
// Assumes load and tick are one-cycle pulses on the system clock.
`timescale 1ns/1ps
module wait_counter #(
    parameter int CNT_W = 8
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic run,
    input wire logic load,
    input wire logic [CNT_W-1:0] load_value,
    input wire logic tick,
    output logic done
);
    logic [CNT_W-1:0] cnt_ff;
    logic armed_ff;
    logic done_ff;

    assign done = done_ff;

    // A value of N sets done on the Nth tick; zero sets it on the first.
    always_ff @(posedge clock) begin
        if (srst || !run) begin
            cnt_ff <= '0;
            armed_ff <= 1'b0;
            done_ff <= 1'b0;
        end else if (load) begin
            cnt_ff <= load_value;
            armed_ff <= 1'b1;
            done_ff <= 1'b0;
        end else if (armed_ff && tick) begin
            if (cnt_ff <= CNT_W'(1)) begin
                cnt_ff <= '0;
                armed_ff <= 1'b0;
                done_ff <= 1'b1;
            end else begin
                cnt_ff <= cnt_ff - 1'b1;
            end
        end
    end
endmodule // wait_counter

// ### tb/osc_source_model.sv
// Crystal and analog PLL stand-in for the clock controller pins.
// Assumes clock is the bench's 200 MHz system clock.
`timescale 1ns/1ps
module osc_source_model (
    input wire logic clock,
    input wire logic osc_on,
    input wire logic a_run,
    input wire logic b_run,
    output logic slow_clk,
    output logic main_osc_clk,
    output logic pll_a_clk,
    output logic pll_b_clk
);
    logic [1:0] ph_ff = 2'h0;
    initial main_osc_clk = 1'b0;
    // The slow clock is permanent, so it runs free in its own phase.
    initial begin
        slow_clk = 1'b0;
        #3.3;
        forever #80 slow_clk = ~slow_clk;
    end
    // bypass clock source
    // An external clock in bypass drives the pin with the enable clear.
    always #10 main_osc_clk = osc_on ? ~main_osc_clk : 1'b0;
    always @(posedge clock) begin
        ph_ff <= ph_ff + 2'h1;
        pll_a_clk <= a_run && ph_ff == 2'h0;
        pll_b_clk <= b_run && ph_ff == 2'h2;
    end
endmodule // osc_source_model

// ### tb/clk_ctrl_asserts.sv
// Port checks of the clock controller, bound into clk_ctrl.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module clk_ctrl_asserts
    import clk_ctrl_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [clk_ctrl_pkg::ADDR_W-1:0] paddr,
    input wire logic [clk_ctrl_pkg::DATA_W-1:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic osc_enable_bit,
    input wire logic osc_bypass_bit,
    input wire logic [clk_ctrl_pkg::DIV_W-1:0] pll_a_div,
    input wire logic [clk_ctrl_pkg::GAIN_W-1:0] pll_a_gain,
    input wire logic pll_a_run,
    input wire logic [clk_ctrl_pkg::DIV_W-1:0] pll_b_div,
    input wire logic [clk_ctrl_pkg::GAIN_W-1:0] pll_b_gain,
    input wire logic pll_b_run,
    input wire logic pmc_irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    logic apb_wr;
    assign apb_wr = psel && penable && pwrite;
    ////////////////////////////////////////
    reset_state_a:
        assert property ($fell(srst) |-> !osc_enable_bit && !pmc_irq
            && pll_a_div == '0 && pll_b_div == '0) else $error("reset");
    run_a_a:
        assert property (pll_a_run == (pll_a_div != '0 && pll_a_gain != '0))
            else $error("pll a run");
    run_b_a:
        assert property (pll_b_run == (pll_b_div != '0 && pll_b_gain != '0))
            else $error("pll b run");
    osc_write_a:
        assert property (apb_wr && paddr == OFS_MOR |=> osc_enable_bit ==
            $past(pwdata[0]) && osc_bypass_bit == $past(pwdata[1]))
            else $error("osc write");
    pll_write_a:
        assert property (apb_wr && paddr == OFS_PLLA |=> pll_a_div ==
            $past(pwdata[7:0]) && pll_a_gain == $past(pwdata[26:16]))
            else $error("pll write");
    hold_regs_a:
        assert property (!apb_wr |=> $stable(osc_enable_bit) &&
            $stable(pll_a_div) && $stable(pll_b_gain)) else $error("hold");
    ready_a:
        assert property (psel && penable |-> pready) else $error("ready");
    err_phase_a:
        assert property (pslverr |-> psel && penable) else $error("slverr");
    cover property ($rose(pmc_irq));
    cover property (pslverr);
    cover property (apb_wr && paddr == OFS_PLLA);
endmodule // clk_ctrl_asserts
bind clk_ctrl clk_ctrl_asserts u_clk_ctrl_asserts (.clock, .srst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .osc_enable_bit,
    .osc_bypass_bit, .pll_a_div, .pll_a_gain, .pll_a_run, .pll_b_div,
    .pll_b_gain, .pll_b_run, .pmc_irq);

// ### tb/clk_ctrl_test.sv
// Self-checking bench for the clock controller over APB.
// Assumes the oscillator model and the bound checker beside it.
`timescale 1ns/1ps
module clk_ctrl_test;
    import clk_ctrl_pkg::*;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic fiq_req = 1'b0;
    logic irq_req = 1'b0;
    logic instr_done = 1'b0;
    logic [31:0] prdata, rd;
    logic [7:0] pll_a_div, pll_b_div;
    logic [10:0] pll_a_gain, pll_b_gain;
    logic pready, pslverr, slow_clk, main_osc_clk, pll_a_clk, pll_b_clk;
    logic osc_enable_bit, osc_bypass_bit, pll_a_run, pll_b_run, err;
    logic master_clk_en, cpu_clk_en, pmc_irq;
    int failures = 0;
    int n_tests = 0;
    int m, c;
    always #2.5 clock = ~clock;
    clk_ctrl u_clk_ctrl (.clock, .srst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .slow_clk, .main_osc_clk,
        .pll_a_clk, .pll_b_clk, .fiq_req, .irq_req, .instr_done,
        .osc_enable_bit, .osc_bypass_bit, .pll_a_div, .pll_a_gain,
        .pll_a_run, .pll_b_div, .pll_b_gain, .pll_b_run, .master_clk_en,
        .cpu_clk_en, .pmc_irq);
    osc_source_model u_osc_source_model (.clock,
        .osc_on(osc_enable_bit | osc_bypass_bit), .a_run(pll_a_run),
        .b_run(pll_b_run), .slow_clk, .main_osc_clk, .pll_a_clk, .pll_b_clk);
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            failures++;
            $display("FAIL %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, e);
    endtask
    task automatic poll(input logic [7:0] a, input logic [31:0] mask);
        for (int k = 0; k < 1000; k++) begin
            apb(1'b0, a, 32'h0000_0000);
            if ((rd & mask) == mask) break;
        end
        chk(rd & mask, mask);
    endtask
    task automatic meas();
        m = 0;
        c = 0;
        repeat (2048) begin
            @(posedge clock);
            if (master_clk_en === 1'b1) m++;
            if (cpu_clk_en === 1'b1) c++;
        end
    endtask
    task automatic results;
        if (failures == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clock);
        srst <= 1'b0;
        rdchk(OFS_MOR, 32'h0000_0000);
        rdchk(OFS_MCKR, 32'h0000_0000);
        rdchk(OFS_PLLB, 32'h0000_0000);
        rdchk(OFS_SCSR, 32'h0000_0001);
        rdchk(OFS_SR, 32'h0000_0008);
        apb(1'b0, 8'h10, 32'h0000_0000);
        chk({rd[30:0], err}, 32'h0000_0001);
        apb(1'b1, OFS_IER, 32'h0000_0003);
        apb(1'b1, OFS_MOR, 32'h0000_0201);
        rdchk(OFS_SR, 32'h0000_0008);
        repeat (190) @(posedge clock);
        rdchk(OFS_SR, 32'h0000_0008);
        poll(OFS_SR, 32'h0000_0001);
        chk(pmc_irq, 1'b1);
        poll(OFS_MCFR, 32'h0001_0000);
        // Counting runs from a slow rise to the sixteenth slow fall.
        chk(rd[15:0] >= 123 && rd[15:0] <= 125, 1'b1);
        apb(1'b1, OFS_MOR, 32'h0000_0000);
        rdchk(OFS_SR, 32'h0000_0008);
        apb(1'b1, OFS_MOR, 32'h0000_0002);
        rdchk(OFS_MOR, 32'h0000_0002);
        apb(1'b1, OFS_PLLA, 32'h2003_0405);
        rdchk(OFS_SR, 32'h0000_0008);
        poll(OFS_SR, 32'h0000_0002);
        chk(pmc_irq, 1'b1);
        apb(1'b1, OFS_IDR, 32'h0000_0002);
        rdchk(OFS_IMR, 32'h0000_0001);
        apb(1'b1, OFS_PLLA, 32'h2003_0405);
        rdchk(OFS_SR, 32'h0000_000a);
        apb(1'b1, OFS_PLLA, 32'h2000_0405);
        rdchk(OFS_SR, 32'h0000_0008);
        apb(1'b1, OFS_PLLB, 32'h0004_0100);
        @(posedge clock);
        chk(pll_b_run, 1'b0);
        for (int p = 0; p < 8; p++) begin
            @(negedge slow_clk);
            apb(1'b1, OFS_MCKR, p < 7 ? p << 2 : 32'h0000_0100);
            rdchk(OFS_SR, 32'h0000_0000);
            poll(OFS_SR, 32'h0000_0008);
            meas();
            chk(m, (64 >> p % 7) >> p / 7);
            chk(c, 64 >> p % 7);
        end
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, OFS_SCDR, 32'h0000_0001);
            meas();
            chk(c != 0, 1'b1);
            instr_done <= 1'b1;
            rdchk(OFS_SCSR, 32'h0000_0000);
            meas();
            chk(c, 0);
            fiq_req <= i == 0;
            irq_req <= i == 1;
            if (i == 2) apb(1'b1, OFS_SCER, 32'h0000_0001);
            rdchk(OFS_SCSR, 32'h0000_0001);
            fiq_req <= 1'b0;
            irq_req <= 1'b0;
            instr_done <= 1'b0;
        end
        results;
    end
    initial begin
        #400_000;
        failures++;
        results;
    end
endmodule // clk_ctrl_test
